// >>> verilog/dil_latch_decoder.sv
// segmented decoder and master/slave hold for the converter switch controls
// assumes code_inputs and sample_strobe_pin come from pins outside the core clock
`include "dil_defs.svh"

module dil_latch_decoder (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_b,
   input  wire logic                      i_sample_strobe_pin,
   input  wire logic [`DIL_CODE_W-1:0]    i_code_inputs,
   input  wire logic                      i_hold,
   output logic                           o_code_ready,
   output logic                           o_word_valid,
   output logic [`DIL_THERM_W-1:0]        o_therm_p,
   output logic [`DIL_THERM_W-1:0]        o_therm_n,
   output logic [`DIL_BIN_W-1:0]          o_bin_p,
   output logic [`DIL_BIN_W-1:0]          o_bin_n,
   output logic [`DIL_LADDER_W-1:0]       o_ladder_p,
   output logic [`DIL_LADDER_W-1:0]       o_ladder_n
);

   dil_pkg::dil_core_state_t st;
   dil_pkg::dil_core_state_t next_st;

   logic [`DIL_UPPER_W-1:0]  upper_code_bits;
   logic [`DIL_LADDER_W-1:0] ladder_code_bits;
   logic [`DIL_THERM_W-1:0]  dec_therm;
   logic [`DIL_WORD_W-1:0]   dec_word;
   logic                     strobe_rise;
   logic                     fifo_out_valid;
   logic [`DIL_WORD_W-1:0]   fifo_out_data;
   logic                     pop;

   // bit 11 is the first data input
   assign upper_code_bits  = st.code_s2[`DIL_CODE_W-1:`DIL_UPPER_LSB];
   assign ladder_code_bits = st.code_s2[`DIL_LADDER_W-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < `DIL_THERM_W; gi++) begin : g_therm
         assign dec_therm[gi] = (upper_code_bits > `DIL_UPPER_W'(gi));
      end
   endgenerate

   // decoded ahead of the master stage
   assign dec_word = {dec_therm,
                      st.code_s2[`DIL_UPPER_LSB-1:`DIL_BIN_CODE_LSB],
                      ladder_code_bits};

   // only the rising edge of the synchronised strobe loads anything
   assign strobe_rise = st.strobe_s2 & ~st.strobe_d;
   assign pop         = strobe_rise & ~i_hold & fifo_out_valid;

   // master stage: every strobe edge offers a decoded word
   dil_fifo #(
      .WIDTH (`DIL_WORD_W),
      .DEPTH (`DIL_FIFO_DEPTH)
   ) u_master (
      .i_core_clk  (i_core_clk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (strobe_rise),
      .o_in_ready  (o_code_ready),
      .i_in_data   (dec_word),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (pop),
      .o_out_data  (fifo_out_data)
   );

   always_comb begin
      next_st           = st;
      next_st.strobe_s1 = i_sample_strobe_pin;
      next_st.strobe_s2 = st.strobe_s1;
      next_st.strobe_d  = st.strobe_s2;
      next_st.code_s1   = i_code_inputs;
      next_st.code_s2   = st.code_s1;
      // slave stage: whole word moves at once, only on a strobe edge
      if (pop) begin
         next_st.word_p = fifo_out_data;
         next_st.word_n = ~fifo_out_data;
         next_st.valid  = 1'b1;
      end
   end

   // reset only clears the word to a known value; it stays invalid until a strobe edge pops a word already in the master stage
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_word_valid = st.valid;
   assign o_therm_p    = st.word_p[`DIL_WORD_W-1:`DIL_THERM_LSB];
   assign o_therm_n    = st.word_n[`DIL_WORD_W-1:`DIL_THERM_LSB];
   assign o_bin_p      = st.word_p[`DIL_THERM_LSB-1:`DIL_BIN_LSB];
   assign o_bin_n      = st.word_n[`DIL_THERM_LSB-1:`DIL_BIN_LSB];
   assign o_ladder_p   = st.word_p[`DIL_BIN_LSB-1:`DIL_LADDER_LSB];
   assign o_ladder_n   = st.word_n[`DIL_BIN_LSB-1:`DIL_LADDER_LSB];

   a_therm_count_match : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      strobe_rise |-> ($countones(dec_word[`DIL_WORD_W-1:`DIL_THERM_LSB])
                       == int'(st.code_s2[11:8])))
      else $error("thermometer line count differs from upper code");

   a_low_bits_pass : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      strobe_rise |-> (dec_word[`DIL_THERM_LSB-1:0] == st.code_s2[7:0]))
      else $error("binary or ladder bits not passed through");

   // lines fill from line 0 upward and never leave a gap
   a_therm_contiguous : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (((o_therm_p + `DIL_THERM_W'(1)) & o_therm_p) == '0))
      else $error("thermometer lines not contiguous");

   a_slave_from_master : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      pop |=> (st.word_p == $past(fifo_out_data)))
      else $error("slave word not taken from master stage");

   // checked against the pin itself, two and three edges back through the synchroniser
   a_capture_on_edge : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      pop |-> ($past(i_sample_strobe_pin, 2) && !$past(i_sample_strobe_pin, 3)))
      else $error("word moved without a strobe rising edge");

   a_switch_stable : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !pop |=> ($stable(o_therm_p) && $stable(o_bin_p) && $stable(o_ladder_p)))
      else $error("switch controls changed between strobe edges");

   // the complement half may only move on a load as well
   a_switch_n_stable : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !pop |=> ($stable(o_therm_n) && $stable(o_bin_n) && $stable(o_ladder_n)))
      else $error("complement controls changed between strobe edges");

   // a held slave stage keeps its whole word while the master fills
   a_hold_freezes : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_hold |=> ($stable(st.word_p) && $stable(st.word_n)))
      else $error("switch word moved while held");

   a_pair_complement : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_word_valid |-> ((o_therm_n == ~o_therm_p) && (o_bin_n == ~o_bin_p)
                        && (o_ladder_n == ~o_ladder_p)))
      else $error("true and complement controls disagree");

   // before the first load both halves rest at zero
   a_idle_until_load : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !o_word_valid |-> ((st.word_p == '0) && (st.word_n == '0)))
      else $error("switch word moved before first load");

   a_valid_holds : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_word_valid |=> o_word_valid)
      else $error("word valid dropped without reset");

   // a full master stage refuses strobes until the slave takes a word
   a_full_stays_full : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (!o_code_ready && !pop) |=> !o_code_ready)
      else $error("full master stage accepted a word");

   a_full_drains : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (!o_code_ready && pop) |=> o_code_ready)
      else $error("master stage still full after a load");

   a_msb_first : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (strobe_rise && st.code_s2[11]) |-> dec_word[`DIL_THERM_LSB+7])
      else $error("first data input not treated as msb");

   a_valid_after_strobe : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_word_valid) |-> $past(pop))
      else $error("word valid without a strobe edge");

endmodule

// >>> pkg/dil_defs.svh
// constants for the converter input latch and decoder
// assumes one core clock; included by the package, the latch decoder and the bench files
`ifndef DIL_DEFS_SVH
`define DIL_DEFS_SVH

`define DIL_CODE_W      12
`define DIL_UPPER_W     4
`define DIL_THERM_W     15
`define DIL_BIN_W       2
`define DIL_LADDER_W    6
`define DIL_WORD_W      23
`define DIL_UPPER_LSB   8
`define DIL_BIN_CODE_LSB 6
`define DIL_THERM_LSB   8
`define DIL_BIN_LSB     6
`define DIL_LADDER_LSB  0
`define DIL_FIFO_DEPTH  16
`define DIL_WORD_RST    23'h000000

`endif

// >>> pkg/dil_pkg.sv
// types for the converter input latch and decoder
// assumes dil_defs.svh is reachable on the include path
`include "dil_defs.svh"

package dil_pkg;

   typedef struct packed {
      logic                      strobe_s1;
      logic                      strobe_s2;
      logic                      strobe_d;
      logic [`DIL_CODE_W-1:0]    code_s1;
      logic [`DIL_CODE_W-1:0]    code_s2;
      logic [`DIL_WORD_W-1:0]    word_p;
      logic [`DIL_WORD_W-1:0]    word_n;
      logic                      valid;
   } dil_core_state_t;

endpackage

// >>> verilog/dil_fifo.sv
// word buffer between master capture and slave switch register
// assumes a single clock and an active low asynchronous reset
module dil_fifo #(
   parameter int WIDTH = 23,
   parameter int DEPTH = 16
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [PW:0]                 cnt;
   } dil_fifo_state_t;

   dil_fifo_state_t st;
   dil_fifo_state_t next_st;
   logic            push;
   logic            pop;

   assign o_in_ready  = (st.cnt != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign o_out_valid = (st.cnt != '0);
   assign o_out_data  = st.mem[st.rd];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = i_in_data;
         next_st.wr         = st.wr + PW'(1);
      end
      if (pop) begin
         next_st.rd = st.rd + PW'(1);
      end
      case ({push, pop})
         2'b10:   next_st.cnt = st.cnt + (PW+1)'(1);
         2'b01:   next_st.cnt = st.cnt - (PW+1)'(1);
         default: next_st.cnt = st.cnt;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_fifo_count_bound : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      st.cnt <= (PW+1)'(DEPTH))
      else $error("fifo count exceeds depth");

endmodule

// >>> tb/dil_src.sv
// sample source model driving the latch strobe pin and code inputs
// assumes the core clock; send is entered just after a rising edge
`include "dil_defs.svh"
module dil_src (
   input  wire logic                   i_core_clk,
   output logic                        o_strobe,
   output logic [`DIL_CODE_W-1:0]      o_code
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_strobe = 1'b0;
      o_code   = '0;
   end
   // bit 11 is the first data input
   task automatic send(input logic [11:0] c, input logic [11:0] junk);
      o_code <= c;
      @(posedge i_core_clk);
      o_strobe <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_code <= junk;
      @(posedge i_core_clk);
      o_strobe <= 1'b0;
      o_code   <= ~junk;
      repeat (2) @(posedge i_core_clk);
   endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the latch decoder, mirroring its word buffer
// assumes dil_src drives the pins and a 100 MHz core clock
`include "dil_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic             i_core_clk = 1'b0;
   logic             i_rst_b    = 1'b0;
   logic             i_hold     = 1'b0;
   logic             strobe, ready, valid;
   logic [11:0]      code;
   wire  [45:0]      seen;
   logic [45:0]      last;
   logic [45:0]      exp_q[$];
   logic [11:0]      buf_q[$];
   int               bad_count  = 0;
   int               num_checks = 0;
   int               seed       = 37;
   always #5 i_core_clk = ~i_core_clk;
   dil_src i_src (.i_core_clk(i_core_clk), .o_strobe(strobe), .o_code(code));
   dil_latch_decoder i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_sample_strobe_pin(strobe), .i_code_inputs(code), .i_hold(i_hold),
      .o_code_ready(ready), .o_word_valid(valid), .o_therm_p(seen[45:31]),
      .o_bin_p(seen[30:29]), .o_ladder_p(seen[28:23]), .o_therm_n(seen[22:8]),
      .o_bin_n(seen[7:6]), .o_ladder_n(seen[5:0]));
   function automatic logic [45:0] expect_of(input logic [11:0] c);
      logic [14:0] t;
      for (int i = 0; i < 15; i++) t[i] = (c[11:8] > i);
      return {t, c[7:6], c[5:0], ~t, ~c[7:6], ~c[5:0]};
   endfunction
   task automatic check(input string what, input logic [45:0] e, input logic [45:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // a strobe pops the oldest buffered word unless held, and pushes unless full
   task automatic strobe_word(input logic [11:0] c, input logic h);
      logic        full;
      logic [31:0] r;
      full = (buf_q.size() == `DIL_FIFO_DEPTH);
      r    = $random(seed);
      i_hold <= h;
      check("code ready", {45'h0, ~full}, {45'h0, ready});
      if (!h && buf_q.size() > 0) exp_q.push_back(expect_of(buf_q.pop_front()));
      if (!full) buf_q.push_back(c);
      i_src.send(c, r[11:0]);
   endtask
   task automatic do_reset();
      i_rst_b <= 1'b0;
      repeat (12) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      @(posedge i_core_clk);
      #1 check("word valid", 46'h0, {45'h0, valid});
      @(posedge i_core_clk);
   endtask
   // each change of the switch word is one whole result
   always @(posedge i_core_clk) begin
      #1;
      if (i_rst_b && valid === 1'b1 && seen !== last) begin
         last = seen;
         if (exp_q.size() == 0) check("unexpected word", '1, seen);
         else check("switch word", exp_q.pop_front(), seen);
      end
   end
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      logic [11:0] tbl[4];
      tbl  = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
      last = '0;
      do_reset();
      for (int n = 0; n < 60; n++) begin
         r = $random(seed);
         strobe_word({r[11:4], 4'(n)}, (n >= 20 && n < 40));
      end
      check("pending words", 46'h0, 46'(exp_q.size()));
      buf_q.delete();
      exp_q.delete();
      last = '0;
      do_reset();
      for (int n = 0; n < 8; n++) strobe_word(tbl[n % 4] ^ 12'(n / 4), 1'b0);
      repeat (4) @(posedge i_core_clk);
      check("pending words", 46'h0, 46'(exp_q.size()));
      close_out();
   end
endmodule
